// File: epwm_core.sv
// Enhanced PWM generator with auto-shutdown and dead band, AXI4-Lite registers
`include "epwm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module epwm_core (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Shutdown sources
    input wire logic int_pin_in,
    input wire logic comparator_in,
    // PWM pins
    output logic pwm_output_a_out,
    output logic pwm_output_a_oe_out,
    output logic pwm_output_b_out,
    output logic pwm_output_b_oe_out
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] period_limit_q;
    logic [7:0] duty_buffer_low_q;
    logic [10:0] capture_pwm_control_q;
    logic [6:0] shutdown_cfg_q;
    logic shutdown_event_flag_q;
    logic [7:0] deadband_control_q;
    logic [7:0] period_timer_count_q;
    logic [7:0] duty_active_reg_q;
    logic [1:0] duty_latch_q;
    logic [5:0] presc_q;
    logic pwm_level_q;
    logic [6:0] db_cnt_q;
    logic [1:0] db_tick_q;
    logic pwm_a_q;
    logic pwm_b_q;
    logic [2:0] int_sync_q;
    logic [2:0] cmp_sync_q;
    logic int_low_q;
    logic cmp_high_q;
    epwm_pkg::epwm_bus_type wstate_q;
    epwm_pkg::epwm_bus_type rstate_q;
    logic [7:0] awaddr_q;
    logic aw_got_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_got_q;
    logic [1:0] bresp_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic pwm_mode;
    logic half_bridge;
    logic [5:0] presc_max;
    logic step;
    logic match;
    logic [9:0] time_base;
    logic [9:0] duty_full;
    logic src_active;
    logic wr_fire;
    logic [31:0] wr_data;
    logic wr_ctl;
    logic wr_sd;
    epwm_pkg::epwm_safe_type safe;
    epwm_pkg::epwm_pins_type pins;

    // Decodes an offset into one hit per register
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction

    assign pwm_mode = (capture_pwm_control_q[`EPWM_CTL_MODE_HI:`EPWM_CTL_MODE_LO] == `EPWM_MODE_PWM);
    assign half_bridge = capture_pwm_control_q[`EPWM_CTL_HALF];

    // ****************************************
    // Prescaler and period timer
    // ****************************************
    // prescale 1, 4 or 16
    always_comb begin
        case (capture_pwm_control_q[`EPWM_CTL_PRE_HI:`EPWM_CTL_PRE_LO])
            `EPWM_PRE_1: presc_max = `EPWM_PRESC_TOP1;
            `EPWM_PRE_4: presc_max = `EPWM_PRESC_TOP4;
            default: presc_max = `EPWM_PRESC_TOP16;
        endcase
    end
    // One timer step per four clocks times the prescale
    assign step = (presc_q == presc_max);
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !pwm_mode) begin
            presc_q <= `EPWM_ZERO6;
        end else if (step) begin
            presc_q <= `EPWM_ZERO6;
        end else begin
            presc_q <= presc_q + `EPWM_ONE6;
        end
    end
    // time base low bits: clock phase at 1:1, else top prescaler bits
    always_comb begin
        case (capture_pwm_control_q[`EPWM_CTL_PRE_HI:`EPWM_CTL_PRE_LO])
            `EPWM_PRE_1: time_base = {period_timer_count_q, presc_q[1:0]};
            `EPWM_PRE_4: time_base = {period_timer_count_q, presc_q[3:2]};
            default: time_base = {period_timer_count_q, presc_q[5:4]};
        endcase
    end
    assign match = (period_timer_count_q == period_limit_q);
    // clear on next increment after match
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !pwm_mode) begin
            period_timer_count_q <= `EPWM_ZERO8;
        end else if (step) begin
            period_timer_count_q <= match ? `EPWM_ZERO8 : period_timer_count_q + `EPWM_ONE2;
        end
    end

    // ****************************************
    // Duty double buffer and compare
    // ****************************************
    // copy only at rollover; bus cannot write the active copy
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            duty_active_reg_q <= `EPWM_ZERO8;
            duty_latch_q <= 2'h0;
        end else if (step && match) begin
            duty_active_reg_q <= duty_buffer_low_q;
            duty_latch_q <= capture_pwm_control_q[`EPWM_CTL_DLSB_HI:`EPWM_CTL_DLSB_LO];
        end
    end
    assign duty_full = {duty_active_reg_q, duty_latch_q};
    // set at period start unless zero; clear on match; no clear past period
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !pwm_mode) begin
            pwm_level_q <= 1'b0;
        end else if (step && match) begin
            pwm_level_q <= ({duty_buffer_low_q, capture_pwm_control_q[5:4]} != `EPWM_ZERO10);
        end else if (time_base == duty_full) begin
            pwm_level_q <= 1'b0;
        end
    end
    // ten-bit compare covers the full limit range

    // ****************************************
    // Dead band
    // ****************************************
    // instruction cycle of four clocks
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            db_tick_q <= 2'h0;
        end else begin
            db_tick_q <= db_tick_q + `EPWM_ONE2;
        end
    end
    // delay only when an output goes active
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            db_cnt_q <= 7'h00;
            pwm_a_q <= 1'b0;
            pwm_b_q <= 1'b0;
        end else if (!half_bridge) begin
            db_cnt_q <= 7'h00;
            pwm_a_q <= pwm_level_q;
            pwm_b_q <= 1'b0;
        end else if (pwm_level_q ? (pwm_a_q && !pwm_b_q) : (pwm_b_q && !pwm_a_q)) begin
            db_cnt_q <= db_cnt_q;
        end else if (pwm_a_q || pwm_b_q) begin
            // Turn-off is immediate; only the turn-on waits
            pwm_a_q <= 1'b0;
            pwm_b_q <= 1'b0;
            db_cnt_q <= deadband_control_q[`EPWM_DB_DELAY_HI:0];
        end else if (db_cnt_q == 7'h00) begin
            pwm_a_q <= pwm_level_q;
            pwm_b_q <= !pwm_level_q;
        end else if (db_tick_q == 2'h3) begin
            db_cnt_q <= db_cnt_q - `EPWM_ONE7;
        end
    end

    // ****************************************
    // Auto-shutdown
    // ****************************************
    // Pin sources pass three flops; change counts when last two agree
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            int_sync_q <= 3'h7;
            cmp_sync_q <= 3'h0;
            int_low_q <= 1'b0;
            cmp_high_q <= 1'b0;
        end else begin
            int_sync_q <= {int_sync_q[1:0], int_pin_in};
            cmp_sync_q <= {cmp_sync_q[1:0], comparator_in};
            if (int_sync_q[2] == int_sync_q[1]) begin
                int_low_q <= !int_sync_q[2];
            end
            if (cmp_sync_q[2] == cmp_sync_q[1]) begin
                cmp_high_q <= cmp_sync_q[2];
            end
        end
    end
    always_comb begin
        case (shutdown_cfg_q[6:4])
            3'h1: src_active = cmp_high_q;
            3'h2: src_active = int_low_q;
            3'h3: src_active = cmp_high_q || int_low_q;
            default: src_active = 1'b0;
        endcase
    end
    // set wins over firmware clear and restart; relies on firmware order
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            shutdown_event_flag_q <= 1'b0;
        end else if (src_active) begin
            shutdown_event_flag_q <= 1'b1;
        end else if (wr_sd) begin
            shutdown_event_flag_q <= wr_data[`EPWM_SD_EVENT];
        end else if (deadband_control_q[`EPWM_DB_RESTART] && step && match) begin
            shutdown_event_flag_q <= 1'b0;
        end
    end
    assign safe = shutdown_cfg_q[3:0];
    always_comb begin
        pins.a_val = pwm_a_q;
        pins.a_oe = pwm_mode;
        pins.b_val = pwm_b_q;
        pins.b_oe = pwm_mode && half_bridge;
        if (src_active || shutdown_event_flag_q) begin
            pins.a_val = safe.drive_a_state[0];
            pins.a_oe = pwm_mode && !safe.drive_a_state[1];
            pins.b_val = safe.drive_b_state[0];
            pins.b_oe = pwm_mode && half_bridge && !safe.drive_b_state[1];
        end
    end
    assign pwm_output_a_out = pins.a_val;
    assign pwm_output_a_oe_out = pins.a_oe;
    assign pwm_output_b_out = pins.b_val;
    assign pwm_output_b_oe_out = pins.b_oe;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign s_axi_awready_out = (wstate_q == epwm_pkg::EPWM_BUS_IDLE) && !aw_got_q;
    assign s_axi_wready_out = (wstate_q == epwm_pkg::EPWM_BUS_IDLE) && !w_got_q;
    assign s_axi_bvalid_out = (wstate_q == epwm_pkg::EPWM_BUS_WRESP);
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = (rstate_q == epwm_pkg::EPWM_BUS_IDLE);
    assign s_axi_rvalid_out = (rstate_q == epwm_pkg::EPWM_BUS_RDATA);
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign wr_fire = (wstate_q == epwm_pkg::EPWM_BUS_IDLE) && aw_got_q && w_got_q;
    assign wr_data = wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wr_ctl = wr_fire && hit(awaddr_q, `EPWM_OFF_CONTROL);
    assign wr_sd = wr_fire && hit(awaddr_q, `EPWM_OFF_SHUTDOWN);
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            wstate_q <= epwm_pkg::EPWM_BUS_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= `EPWM_ZERO8;
            wdata_q <= `EPWM_ZERO32;
            wstrb_q <= 4'h0;
            bresp_q <= `EPWM_RESP_OK;
        end else begin
            case (wstate_q)
                epwm_pkg::EPWM_BUS_IDLE: begin
                    if (s_axi_awvalid_in && !aw_got_q) begin
                        aw_got_q <= 1'b1;
                        awaddr_q <= s_axi_awaddr_in;
                    end
                    if (s_axi_wvalid_in && !w_got_q) begin
                        w_got_q <= 1'b1;
                        wdata_q <= s_axi_wdata_in;
                        wstrb_q <= s_axi_wstrb_in;
                    end
                    if (wr_fire) begin
                        wstate_q <= epwm_pkg::EPWM_BUS_WRESP;
                        aw_got_q <= 1'b0;
                        w_got_q <= 1'b0;
                        bresp_q <= (awaddr_q > `EPWM_OFF_DUTY_ACTIVE) ? `EPWM_RESP_ERR : `EPWM_RESP_OK;
                    end
                end
                epwm_pkg::EPWM_BUS_WRESP: begin
                    if (s_axi_bready_in) begin
                        wstate_q <= epwm_pkg::EPWM_BUS_IDLE;
                    end
                end
                default: wstate_q <= epwm_pkg::EPWM_BUS_IDLE;
            endcase
        end
    end
    // duty high bits and low pair; active copy not writable
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            period_limit_q <= `EPWM_PL_RESET;
            duty_buffer_low_q <= `EPWM_ZERO8;
            capture_pwm_control_q <= 11'h000;
            shutdown_cfg_q <= 7'h00;
            deadband_control_q <= `EPWM_ZERO8;
        end else if (wr_fire) begin
            if (hit(awaddr_q, `EPWM_OFF_PERIOD_LIMIT) && wstrb_q[0]) begin
                period_limit_q <= wdata_q[7:0];
            end
            if (hit(awaddr_q, `EPWM_OFF_DUTY_LOW) && wstrb_q[0]) begin
                duty_buffer_low_q <= wdata_q[7:0];
            end
            if (wr_ctl) begin
                capture_pwm_control_q <= wr_data[10:0];
            end
            if (wr_sd) begin
                shutdown_cfg_q <= wr_data[6:0];
            end
            if (hit(awaddr_q, `EPWM_OFF_DEADBAND) && wstrb_q[0]) begin
                deadband_control_q <= wdata_q[7:0];
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rstate_q <= epwm_pkg::EPWM_BUS_IDLE;
            rdata_q <= `EPWM_ZERO32;
            rresp_q <= `EPWM_RESP_OK;
        end else begin
            case (rstate_q)
                epwm_pkg::EPWM_BUS_IDLE: begin
                    if (s_axi_arvalid_in) begin
                        rstate_q <= epwm_pkg::EPWM_BUS_RDATA;
                        rresp_q <= `EPWM_RESP_OK;
                        rdata_q <= `EPWM_ZERO32;
                        if (hit(s_axi_araddr_in, `EPWM_OFF_PERIOD_LIMIT)) begin
                            rdata_q[7:0] <= period_limit_q;
                        end else if (hit(s_axi_araddr_in, `EPWM_OFF_DUTY_LOW)) begin
                            rdata_q[7:0] <= duty_buffer_low_q;
                        end else if (hit(s_axi_araddr_in, `EPWM_OFF_CONTROL)) begin
                            rdata_q[10:0] <= capture_pwm_control_q;
                        end else if (hit(s_axi_araddr_in, `EPWM_OFF_SHUTDOWN)) begin
                            rdata_q[7:0] <= {shutdown_event_flag_q, shutdown_cfg_q};
                        end else if (hit(s_axi_araddr_in, `EPWM_OFF_DEADBAND)) begin
                            rdata_q[7:0] <= deadband_control_q;
                        end else if (hit(s_axi_araddr_in, `EPWM_OFF_TIMER)) begin
                            rdata_q[7:0] <= period_timer_count_q;
                        end else if (hit(s_axi_araddr_in, `EPWM_OFF_DUTY_ACTIVE)) begin
                            rdata_q[7:0] <= duty_active_reg_q;
                        end else begin
                            rresp_q <= `EPWM_RESP_ERR;
                        end
                    end
                end
                epwm_pkg::EPWM_BUS_RDATA: begin
                    if (s_axi_rready_in) begin
                        rstate_q <= epwm_pkg::EPWM_BUS_IDLE;
                    end
                end
                default: rstate_q <= epwm_pkg::EPWM_BUS_IDLE;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_timer_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (pwm_mode && step && match) |=> (period_timer_count_q == `EPWM_ZERO8))
        else $error("timer not cleared after match");
    chk_duty_copy: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (step && match) |=> (duty_active_reg_q == $past(duty_buffer_low_q)))
        else $error("duty not copied at rollover");
    chk_duty_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !(step && match) |=> $stable(duty_active_reg_q))
        else $error("active duty changed mid period");
    chk_pin_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (pwm_mode && !(step && match) && time_base == duty_full) |=> !pwm_level_q)
        else $error("output not cleared on duty match");
    chk_zero_duty: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (pwm_mode && step && match && {duty_buffer_low_q, capture_pwm_control_q[5:4]} == `EPWM_ZERO10)
        |=> !pwm_level_q)
        else $error("zero duty set the pin");
    chk_flag_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
        src_active |=> shutdown_event_flag_q)
        else $error("shutdown flag not set");
    chk_safe_force: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (shutdown_event_flag_q && pwm_mode) |-> (pwm_output_a_out == safe.drive_a_state[0]
        && pwm_output_a_oe_out == !safe.drive_a_state[1]))
        else $error("pin A not in safe state");
    chk_no_overlap: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !(pwm_a_q && pwm_b_q))
        else $error("both half-bridge outputs active");
endmodule
`default_nettype wire

// File: epwm_map.svh
// Register offsets, field positions and reset values of the enhanced PWM block
`ifndef EPWM_MAP_SVH
`define EPWM_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define EPWM_OFF_PERIOD_LIMIT 8'h00
`define EPWM_OFF_DUTY_LOW 8'h04
`define EPWM_OFF_CONTROL 8'h08
`define EPWM_OFF_SHUTDOWN 8'h0C
`define EPWM_OFF_DEADBAND 8'h10
`define EPWM_OFF_TIMER 8'h14
`define EPWM_OFF_DUTY_ACTIVE 8'h18
// ****************************************
// Field positions
// ****************************************
`define EPWM_CTL_DLSB_HI 5
`define EPWM_CTL_DLSB_LO 4
`define EPWM_CTL_MODE_HI 3
`define EPWM_CTL_MODE_LO 0
`define EPWM_CTL_PRE_HI 9
`define EPWM_CTL_PRE_LO 8
`define EPWM_CTL_HALF 10
`define EPWM_SD_PSSB_HI 1
`define EPWM_SD_PSSB_LO 0
`define EPWM_SD_PSSA_HI 3
`define EPWM_SD_PSSA_LO 2
`define EPWM_SD_SRC_HI 6
`define EPWM_SD_SRC_LO 4
`define EPWM_SD_EVENT 7
`define EPWM_DB_DELAY_HI 6
`define EPWM_DB_RESTART 7
// ****************************************
// Values
// ****************************************
`define EPWM_MODE_PWM 4'hC
`define EPWM_PRE_1 2'h0
`define EPWM_PRE_4 2'h1
`define EPWM_ZERO8 8'h00
`define EPWM_ZERO10 10'h000
`define EPWM_ZERO32 32'h0000_0000
`define EPWM_PL_RESET 8'hFF
`define EPWM_ONE2 2'h1
`define EPWM_ONE4 4'h1
`define EPWM_ONE7 7'h01
`define EPWM_PRE_MAX4 4'hF
`define EPWM_PRE_MAX1 4'h3
`define EPWM_PRE_MAX0 4'h0
`define EPWM_PRESC_TOP1 6'h03
`define EPWM_PRESC_TOP4 6'h0F
`define EPWM_PRESC_TOP16 6'h3F
`define EPWM_ZERO6 6'h00
`define EPWM_ONE6 6'h01
`define EPWM_RESP_OK 2'h0
`define EPWM_RESP_ERR 2'h2
`endif

// File: epwm_pkg.sv
// Types shared by the enhanced PWM block
`default_nettype none
package epwm_pkg;
    typedef struct packed {
        logic [1:0] drive_a_state;
        logic [1:0] drive_b_state;
    } epwm_safe_type;
    typedef struct packed {
        logic a_val;
        logic a_oe;
        logic b_val;
        logic b_oe;
    } epwm_pins_type;
    typedef enum logic [2:0] {
        EPWM_BUS_IDLE = 3'h1,
        EPWM_BUS_WRESP = 3'h2,
        EPWM_BUS_RDATA = 3'h4
    } epwm_bus_type;
endpackage
`default_nettype wire

// File: epwm_bridge_model.sv
// Half-bridge switch pair model that counts shoot-through
`timescale 1ns/100ps
`default_nettype none
module epwm_bridge_model (
    // Clock
    input wire logic clk_in,
    // Gate drives from the two outputs
    input wire logic hi_in,
    input wire logic hi_oe_in,
    input wire logic lo_in,
    input wire logic lo_oe_in,
    // Cycles with both switches on
    output logic [15:0] overlap_out
);
    // A released gate is off, so only a driven high turns a switch on
    initial overlap_out = 16'h0000;
    // both switches must never conduct together
    always @(posedge clk_in) begin
        if (hi_oe_in && hi_in && lo_oe_in && lo_in) begin
            overlap_out <= overlap_out + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the enhanced PWM block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_in, nrst_in, awv, wv, bry, arv, rry, intp, cmp;
    logic awr, wr, bv, arr, rv, pa, pa_oe, pb, pb_oe;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, got;
    logic [3:0] ws;
    logic [1:0] br, rr, resp;
    logic [15:0] ovl;
    int errors, checks, i;
    // Rows: offset, write data, read back, response
    logic [31:0] tab [6][4] = '{'{32'h00, 32'h12, 32'h12, 32'h0}, '{32'h04, 32'hA5, 32'hA5, 32'h0},
        '{32'h08, 32'h30, 32'h30, 32'h0}, '{32'h10, 32'h7F, 32'h7F, 32'h0},
        '{32'h18, 32'h55, 32'h00, 32'h0}, '{32'h1C, 32'h01, 32'h00, 32'h2}};
    epwm_core uut (.clk_in(clk_in), .nrst_in(nrst_in), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .int_pin_in(intp),
        .comparator_in(cmp), .pwm_output_a_out(pa), .pwm_output_a_oe_out(pa_oe),
        .pwm_output_b_out(pb), .pwm_output_b_oe_out(pb_oe));
    epwm_bridge_model model (.clk_in(clk_in), .hi_in(pa), .hi_oe_in(pa_oe), .lo_in(pb), .lo_oe_in(pb_oe),
        .overlap_out(ovl));
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_in);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) begin
                resp = br;
                bry <= 1'b0;
                break;
            end
        end
        if (n == 100) errors++;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int n;
        @(posedge clk_in);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_in);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin
                got = rd;
                resp = rr;
                rry <= 1'b0;
                break;
            end
        end
        if (n == 100) errors++;
    endtask
    // Bounded wait for the next period start on output A
    task automatic wait_rise;
        int n;
        for (n = 0; n < 40000 && pa !== 1'b0; n++) @(posedge clk_in);
        for (n = 0; n < 40000 && pa !== 1'b1; n++) @(posedge clk_in);
        if (n == 40000) errors++;
    endtask
    task complete_run;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****
    // Stimulus
    // ****
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        #(9000000);
        errors++;
        complete_run;
    end
    initial begin
        {nrst_in, awv, wv, bry, arv, rry, cmp} = 7'h00;
        intp = 1'b1;
        {awa, ara, wd} = 48'h0;
        ws = 4'hF;
        errors = 0;
        checks = 0;
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rd_reg(8'(i * 4));
            chk(got, (i == 0) ? 32'h0000_00FF : 32'h0000_0000);
        end
        for (i = 0; i < 6; i++) begin
            wr_reg(tab[i][0][7:0], tab[i][1]);
            chk(32'(resp), tab[i][3]);
            rd_reg(tab[i][0][7:0]);
            chk(got, tab[i][2]);
            chk(32'(resp), tab[i][3]);
        end
        // Duty is double buffered and latched at rollover
        wr_reg(8'h00, 32'hFF);
        wr_reg(8'h04, 32'h40);
        wr_reg(8'h08, 32'h10C);
        wait_rise;
        wr_reg(8'h04, 32'h80);
        wr_reg(8'h18, 32'hFF);
        rd_reg(8'h18);
        chk(got, 32'h40);
        wait_rise;
        rd_reg(8'h18);
        chk(got, 32'h80);
        wr_reg(8'h00, 32'h03);
        wr_reg(8'h04, 32'h02);
        wr_reg(8'h08, 32'h0C);
        repeat (1200) @(posedge clk_in);
        for (i = 0; i < 12; i++) begin
            rd_reg(8'h14);
            chk({2'h0, got[31:2]}, 32'h0);
        end
        // Comparator shutdown: A driven high, B released
        wr_reg(8'h0C, 32'h16);
        cmp <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk(32'({pa, pa_oe, pb_oe}), 32'h6);
        rd_reg(8'h0C);
        chk(got, 32'h96);
        cmp <= 1'b0;
        repeat (200) @(posedge clk_in);
        rd_reg(8'h0C);
        chk(got, 32'h96);
        wr_reg(8'h0C, 32'h16);
        rd_reg(8'h0C);
        chk(got, 32'h16);
        wr_reg(8'h0C, 32'h20);
        intp <= 1'b0;
        repeat (8) @(posedge clk_in);
        chk(32'({pa, pa_oe}), 32'h1);
        intp <= 1'b1;
        wr_reg(8'h10, 32'h80);
        repeat (200) @(posedge clk_in);
        rd_reg(8'h0C);
        chk(got, 32'h20);
        wr_reg(8'h10, 32'h00);
        wr_reg(8'h0C, 32'h8C);
        repeat (4) @(posedge clk_in);
        chk(32'(pa_oe), 32'h0);
        wr_reg(8'h0C, 32'h00);
        // Half bridge with dead band, partner counts overlap
        wr_reg(8'h10, 32'h03);
        wr_reg(8'h08, 32'h40C);
        repeat (400) @(posedge clk_in);
        chk(32'(pb_oe), 32'h1);
        chk(32'(ovl), 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire
